// [rtl/rsw_pkg.sv]
// Purpose: Constants and carriers for the sleep, countdown and watchdog block
// Assumes: Register index = printed offset, byte address = 4 * index
// Notes: All time bases count in 1/4096 s units
package rsw_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam logic [7:0] IDX_SLEEP = 8'h17;
    localparam logic [7:0] IDX_CD_CTRL = 8'h18;
    localparam logic [7:0] IDX_CD_VAL = 8'h19;
    localparam logic [7:0] IDX_CD_RLD = 8'h1a;
    localparam logic [7:0] IDX_WD = 8'h1b;
    localparam logic [7:0] IDX_STAT = 8'h1e;
    localparam logic [7:0] RST_SLEEP = 8'h00;
    localparam logic [7:0] RST_CD_CTRL = 8'h23;
    localparam logic [7:0] RST_CD_VAL = 8'h00;
    localparam logic [7:0] RST_CD_RLD = 8'h00;
    localparam logic [7:0] RST_WD = 8'h00;
    // Sleep control fields
    localparam int SL_REQ = 7;
    localparam int SL_RES = 6;
    localparam int SL_BPOL = 5;
    localparam int SL_APOL = 4;
    localparam int SL_SEEN = 3;
    // Countdown control fields
    localparam int CD_RUN = 7;
    localparam int CD_STYLE = 6;
    localparam int CD_RPT = 5;
    localparam int CD_ALM_HI = 4;
    localparam int CD_ALM_LO = 2;
    // Watchdog fields
    localparam int WD_STEER = 7;
    localparam int WD_LIM_HI = 6;
    localparam int WD_LIM_LO = 2;
    // Status fields
    localparam int ST_CD = 0;
    localparam int ST_WD = 1;
    // Time base: one crystal tick is one unit, one RC tick is 32 units
    localparam logic [12:0] STEP_XT = 13'h0001;
    localparam logic [12:0] STEP_RC = 13'h0020;
    localparam int BIT_SLEEP_PER = 5;
    localparam int BIT_64HZ = 6;
    localparam int BIT_16HZ = 8;
    localparam int BIT_4HZ = 10;
    localparam int BIT_1HZ = 12;
    localparam logic [5:0] SEC_LAST = 6'h3b;
    localparam logic [6:0] PW_4096 = 7'h01;
    localparam logic [6:0] PW_128 = 7'h20;
    localparam logic [6:0] PW_64 = 7'h40;
    localparam int unsigned RC_PULSE_NS = 100_000;
    localparam int unsigned RC_PULSE_CYC =
        (RC_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam logic [4:0] WD_RST_CYC = 5'h10;

    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_RUN = 2'b01,
        WD_RST = 2'b10
    } rsw_wd_st_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rsw_apb_req_t;
endpackage

// [rtl/rsw_top.sv]
// Purpose: Sleep request, edge polarity, countdown timer and watchdog
// Assumes: base_tick is a one-cycle pulse at 4096 Hz (crystal) or
//          128 Hz (rc_mode high), on pclk
// Notes: APB slave, one wait state per access
// Summary of operation
// - Writing sleep request moves power SM on; clears when SM back in run
// - Sleep request write ignored while stopped or no interrupt enabled
// - Sleep reset option drives reset output low during sleep state
// - Second edge input triggers on rising or falling edge per its polarity
// - First edge input triggers on rising or falling edge per its polarity
// - Sleep-entered flag sets on each entry into sleep
// - Sleep entered after N to N+1 periods of 7.8 ms; zero is immediate
// - Countdown decrements only while enabled, else holds value
// - Level interrupt held until flag clear; pulse ends on width or clear
// - Repeat mode reloads at zero; single mode halts at zero
// - Alarm repeat field picks which time fields must match
// - Hundredths value FF every hundredth, Fx every tenth; RC once a second
// - Countdown clock 4 kHz or 128 Hz, 64 Hz, 1 Hz, 1/60 Hz
// - Pulse width chosen by clock select, style, repeat and oscillator
// - Countdown value resets to zero, writable while stopped
// - Repeat period equals initial value times countdown period
// - Watchdog timeout raises interrupt or reset per steering bit
// - Watchdog cycle count sets timeout; zero disables watchdog
// - Watchdog clock 16 Hz, 4 Hz, 1 Hz or 1/4 Hz
// - Countdown control resets to 0x23
// - Countdown reaching zero with enable sets flag and interrupt
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module rsw_top
    import rsw_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire rsw_apb_req_t apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic base_tick,
    input wire logic rc_mode,
    input wire logic stop_in,
    input wire logic any_irq_en,
    input wire logic countdown_irq_enable,
    input wire logic pwr_in_sleep,
    input wire logic pwr_in_run,
    input wire logic event_in_a_pin,
    input wire logic event_in_b_pin,
    input wire logic [7:0] alarm_centisecond_value,
    output logic sleep_wait_state,
    output logic sleep_enter,
    output logic reset_out_n,
    output logic edge_irq_a,
    output logic edge_irq_b,
    output logic interrupt_out_n,
    output logic watchdog_interrupt,
    output logic [6:0] alarm_field_mask,
    output logic [1:0] alarm_centi_mode
);
    typedef struct packed {
        logic [7:0] sleep;
        logic [7:0] cd_ctrl;
        logic [7:0] cd_val;
        logic [7:0] cd_rld;
        logic [7:0] wd;
        logic cd_flag;
        logic wd_flag;
        logic [11:0] units;
        logic [5:0] secs;
        logic [1:0] quarter;
        logic [3:0] slp_cnt;
        logic slp_done;
        logic seen_sleep;
        logic sleep_prev;
        logic a1, a2, a3, b1, b2, b3;
        logic [4:0] wd_cnt;
        rsw_wd_st_t wd_st;
        logic [4:0] wd_rst_cnt;
        logic pulse_on;
        logic pulse_rc;
        logic [6:0] pw_units;
        logic [11:0] rc_cnt;
        logic ready;
        logic err;
        logic [31:0] rdata;
        logic o_wait, o_enter, o_rst_n, o_ea, o_eb, o_irq_n;
        logic [6:0] o_mask;
        logic [1:0] o_cmode;
    } rsw_state_t;

    rsw_state_t s_q, s_d;

    // True when a step from o to n crosses a multiple of 2**k
    function automatic logic crossed(input logic [12:0] o,
        input logic [12:0] n, input int k);
        crossed = (o >> k) != (n >> k);
    endfunction

    function automatic logic [6:0] alarm_mask(input logic [2:0] sel);
        case (sel)
            3'h7: alarm_mask = 7'h01;
            3'h6: alarm_mask = 7'h03;
            3'h5: alarm_mask = 7'h07;
            3'h4: alarm_mask = 7'h0f;
            3'h3: alarm_mask = 7'h1f;
            3'h2: alarm_mask = 7'h2f;
            3'h1: alarm_mask = 7'h6f;
            default: alarm_mask = 7'h00;
        endcase
    endfunction

    logic [12:0] unit_sum;
    logic t_slp, t_64, t_16, t_4, t_sec, t_min, t_qtr;
    logic cd_tick, wd_tick, cd_evt, level_mode, rc_short;
    logic acc, done, hit, wr, rd;
    logic [7:0] idx, wdat;
    logic [6:0] pw, pw_step;

    always_comb begin
        s_d = s_q;
        unit_sum = {1'b0, s_q.units} + (rc_mode ? STEP_RC : STEP_XT);
        t_slp = base_tick && crossed({1'b0, s_q.units}, unit_sum,
            BIT_SLEEP_PER);
        t_64 = base_tick && crossed({1'b0, s_q.units}, unit_sum, BIT_64HZ);
        t_16 = base_tick && crossed({1'b0, s_q.units}, unit_sum, BIT_16HZ);
        t_4 = base_tick && crossed({1'b0, s_q.units}, unit_sum, BIT_4HZ);
        t_sec = base_tick && crossed({1'b0, s_q.units}, unit_sum, BIT_1HZ);
        t_min = t_sec && (s_q.secs == SEC_LAST);
        t_qtr = t_sec && (s_q.quarter == 2'b11);
        if (base_tick) begin
            s_d.units = unit_sum[11:0];
        end
        if (t_sec) begin
            s_d.secs = t_min ? 6'h00 : s_q.secs + 6'h01;
            s_d.quarter = s_q.quarter + 2'b01;
        end

        // Register access; write and read side effects at completion
        idx = apb.paddr[9:2];
        wdat = apb.pwdata[7:0];
        acc = apb.psel && apb.penable;
        done = acc && s_q.ready;
        hit = (apb.paddr[11:10] == 2'b00) && (apb.paddr[1:0] == 2'b00) &&
            (idx inside {IDX_SLEEP, IDX_CD_CTRL, IDX_CD_VAL, IDX_CD_RLD,
            IDX_WD, IDX_STAT});
        wr = done && apb.pwrite && hit;
        rd = done && !apb.pwrite && hit;
        s_d.ready = acc && !s_q.ready;
        s_d.err = 1'b0;
        if (acc && !s_q.ready) begin
            s_d.err = !hit;
            // Refused accesses read zero, even at a mapped index
            case (hit ? idx : 8'h00)
                IDX_SLEEP: s_d.rdata = {24'h0, s_q.sleep};
                IDX_CD_CTRL: s_d.rdata = {24'h0, s_q.cd_ctrl};
                IDX_CD_VAL: s_d.rdata = {24'h0, s_q.cd_val};
                IDX_CD_RLD: s_d.rdata = {24'h0, s_q.cd_rld};
                IDX_WD: s_d.rdata = {24'h0, s_q.wd};
                IDX_STAT: s_d.rdata = {30'h0, s_q.wd_flag, s_q.cd_flag};
                default: s_d.rdata = 32'h0;
            endcase
        end

        // Sleep request and delay
        if (wr && idx == IDX_SLEEP) begin
            s_d.sleep[SL_RES:SL_APOL] = wdat[SL_RES:SL_APOL];
            s_d.sleep[2:0] = wdat[2:0];
            s_d.sleep[SL_REQ] = wdat[SL_REQ] && !stop_in && any_irq_en;
        end
        if (s_q.sleep[SL_REQ] && pwr_in_sleep) begin
            s_d.seen_sleep = 1'b1;
        end
        if (s_q.seen_sleep && pwr_in_run) begin
            s_d.sleep[SL_REQ] = 1'b0;
            s_d.seen_sleep = 1'b0;
        end
        // Read clears the entered flag, but a new entry in the same cycle wins
        if (rd && idx == IDX_SLEEP) begin
            s_d.sleep[SL_SEEN] = 1'b0;
        end
        s_d.sleep_prev = pwr_in_sleep;
        if (pwr_in_sleep && !s_q.sleep_prev) begin
            s_d.sleep[SL_SEEN] = 1'b1;
        end
        // Boundaries of 1/128 s: first comes in 0..1 period, so N+1 of them
        // lie between N and N+1 periods after the request
        if (!s_q.sleep[SL_REQ]) begin
            s_d.slp_cnt = 4'h0;
            s_d.slp_done = 1'b0;
        end else if (s_q.sleep[2:0] == 3'h0) begin
            s_d.slp_done = 1'b1;
        end else if (t_slp && !s_q.slp_done) begin
            s_d.slp_cnt = s_q.slp_cnt + 4'h1;
            s_d.slp_done = (s_q.slp_cnt == {1'b0, s_q.sleep[2:0]});
        end
        s_d.o_wait = s_q.sleep[SL_REQ];
        s_d.o_enter = s_q.sleep[SL_REQ] && s_q.slp_done;

        // Edge inputs
        s_d.a1 = event_in_a_pin;
        s_d.a2 = s_q.a1;
        s_d.a3 = s_q.a2;
        s_d.b1 = event_in_b_pin;
        s_d.b2 = s_q.b1;
        s_d.b3 = s_q.b2;
        s_d.o_ea = s_q.sleep[SL_APOL] ? (s_q.a2 && !s_q.a3) :
            (!s_q.a2 && s_q.a3);
        s_d.o_eb = s_q.sleep[SL_BPOL] ? (s_q.b2 && !s_q.b3) :
            (!s_q.b2 && s_q.b3);

        // Countdown timer
        if (wr && idx == IDX_CD_CTRL) begin
            s_d.cd_ctrl = wdat;
        end
        if (wr && idx == IDX_CD_RLD) begin
            s_d.cd_rld = wdat;
        end
        case (s_q.cd_ctrl[1:0])
            2'b00: cd_tick = base_tick;
            2'b01: cd_tick = t_64;
            2'b10: cd_tick = t_sec;
            default: cd_tick = t_min;
        endcase
        level_mode = s_q.cd_ctrl[CD_STYLE] && !s_q.cd_ctrl[CD_RPT];
        rc_short = s_q.cd_ctrl[CD_STYLE] && s_q.cd_ctrl[CD_RPT];
        cd_evt = 1'b0;
        // Halting the tick is all the gating needed for the held value
        if (s_q.cd_ctrl[CD_RUN] && cd_tick) begin
            if (s_q.cd_val == 8'h01 ||
                (s_q.cd_val == 8'h00 && s_q.cd_ctrl[CD_RPT])) begin
                cd_evt = 1'b1;
                s_d.cd_val = s_q.cd_ctrl[CD_RPT] ? s_q.cd_rld : 8'h00;
            end else if (s_q.cd_val != 8'h00) begin
                s_d.cd_val = s_q.cd_val - 8'h01;
            end
        end
        if (wr && idx == IDX_CD_VAL && !s_q.cd_ctrl[CD_RUN]) begin
            s_d.cd_val = wdat;
        end
        case (s_q.cd_ctrl[1:0])
            2'b00: pw = rc_mode ? PW_128 : PW_4096;
            2'b01: pw = PW_128;
            default: pw = PW_64;
        endcase
        if (rc_short) begin
            pw = PW_4096;
        end
        // Width counts down by one time base step, not by the phase
        pw_step = rc_mode ? STEP_RC[6:0] : STEP_XT[6:0];
        if (wr && idx == IDX_STAT && wdat[ST_CD]) begin
            s_d.cd_flag = 1'b0;
            s_d.pulse_on = 1'b0;
        end
        if (s_q.pulse_on) begin
            if (s_q.pulse_rc) begin
                s_d.rc_cnt = s_q.rc_cnt - 12'h001;
                s_d.pulse_on = s_q.rc_cnt != 12'h001;
            end else if (base_tick) begin
                s_d.pw_units = (s_q.pw_units > pw_step) ?
                    s_q.pw_units - pw_step : 7'h00;
                s_d.pulse_on = s_q.pw_units > pw_step;
            end
        end
        if (cd_evt && countdown_irq_enable) begin
            s_d.cd_flag = 1'b1;
            s_d.pulse_on = !level_mode;
            s_d.pulse_rc = rc_short && rc_mode;
            s_d.pw_units = pw;
            s_d.rc_cnt = RC_PULSE_CYC[11:0];
        end
        s_d.o_irq_n = !(s_q.cd_flag && (level_mode || s_q.pulse_on));

        // Alarm match selection
        s_d.o_mask = alarm_mask(s_q.cd_ctrl[CD_ALM_HI:CD_ALM_LO]);
        s_d.o_cmode = 2'b00;
        if (s_q.cd_ctrl[CD_ALM_HI:CD_ALM_LO] == 3'h7 && !rc_mode) begin
            if (alarm_centisecond_value == 8'hff) begin
                s_d.o_cmode = 2'b10;
            end else if (alarm_centisecond_value[7:4] == 4'hf) begin
                s_d.o_cmode = 2'b01;
            end
        end

        // Watchdog
        case (s_q.wd[1:0])
            2'b00: wd_tick = t_16;
            2'b01: wd_tick = t_4;
            2'b10: wd_tick = t_sec;
            default: wd_tick = t_qtr;
        endcase
        if (wr && idx == IDX_STAT && wdat[ST_WD]) begin
            s_d.wd_flag = 1'b0;
        end
        case (s_q.wd_st)
            WD_IDLE: begin
            end
            WD_RUN: begin
                if (wd_tick) begin
                    s_d.wd_cnt = s_q.wd_cnt - 5'h01;
                    if (s_q.wd_cnt == 5'h01) begin
                        if (s_q.wd[WD_STEER]) begin
                            s_d.wd_st = WD_RST;
                            s_d.wd_rst_cnt = WD_RST_CYC;
                        end else begin
                            s_d.wd_st = WD_IDLE;
                            s_d.wd_flag = 1'b1;
                        end
                    end
                end
            end
            WD_RST: begin
                s_d.wd_rst_cnt = s_q.wd_rst_cnt - 5'h01;
                if (s_q.wd_rst_cnt == 5'h01) begin
                    s_d.wd_st = WD_IDLE;
                end
            end
            default: s_d.wd_st = WD_IDLE;
        endcase
        if (wr && idx == IDX_WD) begin
            s_d.wd = wdat;
            s_d.wd_cnt = wdat[WD_LIM_HI:WD_LIM_LO];
            s_d.wd_st = (wdat[WD_LIM_HI:WD_LIM_LO] == 5'h00) ?
                WD_IDLE : WD_RUN;
        end
        s_d.o_rst_n = !((s_q.sleep[SL_RES] && pwr_in_sleep) ||
            s_q.wd_st == WD_RST);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.sleep <= RST_SLEEP;
            s_q.cd_ctrl <= RST_CD_CTRL;
            s_q.cd_val <= RST_CD_VAL;
            s_q.cd_rld <= RST_CD_RLD;
            s_q.wd <= RST_WD;
            s_q.wd_st <= WD_IDLE;
            s_q.o_rst_n <= 1'b1;
            s_q.o_irq_n <= 1'b1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.err;
    assign sleep_wait_state = s_q.o_wait;
    assign sleep_enter = s_q.o_enter;
    assign reset_out_n = s_q.o_rst_n;
    assign edge_irq_a = s_q.o_ea;
    assign edge_irq_b = s_q.o_eb;
    assign interrupt_out_n = s_q.o_irq_n;
    assign watchdog_interrupt = s_q.wd_flag;
    assign alarm_field_mask = s_q.o_mask;
    assign alarm_centi_mode = s_q.o_cmode;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn || !clk_en);

    property p_slp_gate;
        wr && idx == IDX_SLEEP && (stop_in || !any_irq_en) &&
            !s_q.sleep[SL_REQ] |=> !s_q.sleep[SL_REQ];
    endproperty
    a_slp_gate: assert property (p_slp_gate)
        else $error("sleep request set while stopped");

    property p_sleep_rst;
        s_q.sleep[SL_RES] && pwr_in_sleep |=> !reset_out_n;
    endproperty
    a_sleep_rst: assert property (p_sleep_rst)
        else $error("reset output not low in sleep");

    property p_edge_b;
        s_q.sleep[SL_BPOL] && s_q.b2 && !s_q.b3 |=> edge_irq_b;
    endproperty
    a_edge_b: assert property (p_edge_b)
        else $error("rising edge on input b missed");

    property p_edge_a;
        !s_q.sleep[SL_APOL] && s_q.a2 && !s_q.a3 |=> !edge_irq_a;
    endproperty
    a_edge_a: assert property (p_edge_a)
        else $error("edge a fired on wrong polarity");

    property p_seen;
        pwr_in_sleep && !s_q.sleep_prev |=> s_q.sleep[SL_SEEN];
    endproperty
    a_seen: assert property (p_seen)
        else $error("sleep entered flag not set");

    property p_no_delay;
        s_q.sleep[SL_REQ] && s_q.sleep[2:0] == 3'h0 && !wr
            |-> ##[1:2] sleep_enter;
    endproperty
    a_no_delay: assert property (p_no_delay)
        else $error("zero delay sleep not immediate");

    property p_hold;
        !s_q.cd_ctrl[CD_RUN] && !wr |=> $stable(s_q.cd_val);
    endproperty
    a_hold: assert property (p_hold)
        else $error("stopped countdown changed");

    property p_level;
        s_q.cd_flag && level_mode |=> !interrupt_out_n;
    endproperty
    a_level: assert property (p_level)
        else $error("level interrupt not held");

    property p_reload;
        s_q.cd_ctrl[CD_RUN] && s_q.cd_ctrl[CD_RPT] && cd_tick &&
            s_q.cd_val == 8'h01 && !wr |=> s_q.cd_val == $past(s_q.cd_rld);
    endproperty
    a_reload: assert property (p_reload)
        else $error("countdown did not reload");

    property p_wd_restart;
        wr && idx == IDX_WD |=> s_q.wd_cnt == $past(wdat[6:2]);
    endproperty
    a_wd_restart: assert property (p_wd_restart)
        else $error("watchdog not restarted by write");

    sequence s_wd_fire;
        s_q.wd_st == WD_RUN && wd_tick && s_q.wd_cnt == 5'h01 &&
            s_q.wd[WD_STEER] && !wr;
    endsequence
    property p_wd_reset;
        s_wd_fire |=> s_q.wd_st == WD_RST ##1 !reset_out_n;
    endproperty
    a_wd_reset: assert property (p_wd_reset)
        else $error("watchdog timeout gave no reset");
endmodule

// [verif/tb_top.sv]
// Purpose: Self-checking bench for the sleep, countdown and watchdog block
// Assumes: base_tick pulses every 8 pclk cycles, crystal time base
// Notes: Register table first, then sleep, edge, countdown, watchdog cases
`timescale 1ns/1ps
module tb_top
    import rsw_pkg::*;
;
    typedef struct packed {
        logic [11:0] addr;
        logic wr;
        logic [31:0] data;
        logic [31:0] exp_rd;
        logic exp_err;
    } rsw_tb_row_t;

    logic pclk, presetn, clk_en, base_tick, rc_mode, stop_in, any_irq_en;
    logic countdown_irq_enable, pwr_in_sleep, pwr_in_run;
    logic event_in_a_pin, event_in_b_pin;
    logic [7:0] alarm_centisecond_value;
    rsw_apb_req_t apb_req;
    logic [31:0] prdata;
    logic pready, pslverr, sleep_wait_state, sleep_enter, reset_out_n;
    logic edge_irq_a, edge_irq_b, interrupt_out_n, watchdog_interrupt;
    logic [6:0] alarm_field_mask;
    logic [1:0] alarm_centi_mode;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0, last_fall = 0, fall_gap = 0, lo_run = 0, lo_len = 0;
    int cnt_a = 0, cnt_b = 0, tick_cnt = 0;
    logic int_n_d = 1'b1;
    logic [31:0] rv;
    logic ev;
    int k;
    logic [6:0] masks [8] = '{7'h00, 7'h6f, 7'h2f, 7'h1f, 7'h0f, 7'h07,
                              7'h03, 7'h01};
    rsw_tb_row_t rows [10] = '{
        '{12'h05c, 1'b0, 32'h0, 32'h00, 1'b0},
        '{12'h060, 1'b0, 32'h0, 32'h23, 1'b0},
        '{12'h064, 1'b0, 32'h0, 32'h00, 1'b0},
        '{12'h068, 1'b0, 32'h0, 32'h00, 1'b0},
        '{12'h06c, 1'b0, 32'h0, 32'h00, 1'b0},
        '{12'h078, 1'b0, 32'h0, 32'h00, 1'b0},
        '{12'h070, 1'b0, 32'h0, 32'h00, 1'b1},
        '{12'h061, 1'b0, 32'h0, 32'h00, 1'b1},
        '{12'h068, 1'b1, 32'hffffff5a, 32'h00, 1'b0},
        '{12'h068, 1'b0, 32'h0, 32'h5a, 1'b0}};

    rsw_top rsw_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .apb(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .base_tick(base_tick), .rc_mode(rc_mode), .stop_in(stop_in),
        .any_irq_en(any_irq_en),
        .countdown_irq_enable(countdown_irq_enable),
        .pwr_in_sleep(pwr_in_sleep), .pwr_in_run(pwr_in_run),
        .event_in_a_pin(event_in_a_pin), .event_in_b_pin(event_in_b_pin),
        .alarm_centisecond_value(alarm_centisecond_value),
        .sleep_wait_state(sleep_wait_state), .sleep_enter(sleep_enter),
        .reset_out_n(reset_out_n), .edge_irq_a(edge_irq_a),
        .edge_irq_b(edge_irq_b), .interrupt_out_n(interrupt_out_n),
        .watchdog_interrupt(watchdog_interrupt),
        .alarm_field_mask(alarm_field_mask),
        .alarm_centi_mode(alarm_centi_mode));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Time base and observers of pulse timing
    always @(posedge pclk) begin
        tick_cnt <= (tick_cnt + 1) % 8;
        base_tick <= (tick_cnt == 7);
        cyc <= cyc + 1;
        int_n_d <= interrupt_out_n;
        if (int_n_d === 1'b1 && interrupt_out_n === 1'b0) begin
            fall_gap <= cyc - last_fall;
            last_fall <= cyc;
        end
        lo_run <= (interrupt_out_n === 1'b0) ? lo_run + 1 : 0;
        if (interrupt_out_n === 1'b1 && lo_run != 0)
            lo_len <= lo_run;
        if (edge_irq_a === 1'b1)
            cnt_a <= cnt_a + 1;
        if (edge_irq_b === 1'b1)
            cnt_b <= cnt_b + 1;
    end

    task automatic complete_run();
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request held until pready is sampled high; no fixed latency assumed
    task automatic bus_xfer(input logic [11:0] a, input logic w,
                            input logic [31:0] d, output logic [31:0] rd,
                            output logic err);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                     pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        bus_xfer(a, 1'b1, d, r, e);
    endtask

    task automatic reg_rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        bus_xfer(a, 1'b0, 32'h0, r, e);
    endtask

    task automatic wait_low(input int lim);
        k = 0;
        while (interrupt_out_n !== 1'b0 && k < lim) begin
            @(posedge pclk);
            k++;
        end
    endtask

    initial begin
        #1_600_000;
        num_errors++;
        complete_run();
    end

    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        rc_mode = 1'b0;
        base_tick = 1'b0;
        stop_in = 1'b1;
        any_irq_en = 1'b1;
        countdown_irq_enable = 1'b1;
        pwr_in_sleep = 1'b0;
        pwr_in_run = 1'b1;
        event_in_a_pin = 1'b0;
        event_in_b_pin = 1'b1;
        alarm_centisecond_value = 8'h00;
        apb_req = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(reset_out_n), 32'h1);
        foreach (rows[i]) begin
            bus_xfer(rows[i].addr, rows[i].wr, rows[i].data, rv, ev);
            chk(32'(ev), 32'(rows[i].exp_err));
            if (!rows[i].wr)
                chk(rv, rows[i].exp_rd);
        end
        // Sleep request refused, then taken with zero delay
        reg_wr(12'h05c, 32'h80);
        reg_rd(12'h05c, rv);
        chk(rv, 32'h00);
        stop_in <= 1'b0;
        any_irq_en <= 1'b0;
        reg_wr(12'h05c, 32'h80);
        reg_rd(12'h05c, rv);
        chk(rv, 32'h00);
        any_irq_en <= 1'b1;
        reg_wr(12'h05c, 32'hc0);
        repeat (3) @(posedge pclk);
        chk(32'(sleep_wait_state), 32'h1);
        chk(32'(sleep_enter), 32'h1);
        pwr_in_sleep <= 1'b1;
        pwr_in_run <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(32'(reset_out_n), 32'h0);
        reg_rd(12'h05c, rv);
        chk(rv, 32'hc8);
        pwr_in_sleep <= 1'b0;
        pwr_in_run <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'(sleep_wait_state), 32'h0);
        chk(32'(reset_out_n), 32'h1);
        // Delay of two periods of 256 cycles each
        reg_wr(12'h05c, 32'h82);
        k = 0;
        while (sleep_enter !== 1'b1 && k < 1000) begin
            @(posedge pclk);
            k++;
        end
        chk(32'(k >= 510 && k <= 780), 32'h1);
        reg_wr(12'h05c, 32'h10);
        repeat (2) @(posedge pclk);
        chk(32'(sleep_wait_state), 32'h0);
        // Edge a rising-sensitive, edge b falling-sensitive
        event_in_a_pin <= 1'b1;
        event_in_b_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        event_in_a_pin <= 1'b0;
        event_in_b_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(32'(cnt_a), 32'h1);
        chk(32'(cnt_b), 32'h1);
        for (int r = 0; r < 8; r++) begin
            reg_wr(12'h060, 32'(r * 4 + 3));
            repeat (2) @(posedge pclk);
            chk(32'(alarm_field_mask), 32'(masks[r]));
        end
        alarm_centisecond_value <= 8'hff;
        repeat (3) @(posedge pclk);
        chk(32'(alarm_centi_mode), 32'h2);
        rc_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'(alarm_centi_mode), 32'h0);
        rc_mode <= 1'b0;
        alarm_centisecond_value <= 8'hf5;
        repeat (3) @(posedge pclk);
        chk(32'(alarm_centi_mode), 32'h1);
        alarm_centisecond_value <= 8'h12;
        repeat (3) @(posedge pclk);
        chk(32'(alarm_centi_mode), 32'h0);
        // Level, single shot, stopped first
        reg_wr(12'h060, 32'h40);
        reg_wr(12'h064, 32'h02);
        repeat (40) @(posedge pclk);
        reg_rd(12'h064, rv);
        chk(rv, 32'h02);
        reg_wr(12'h060, 32'hc0);
        // Frozen clock enable: no tick may reach the running countdown
        clk_en <= 1'b0;
        repeat (40) @(posedge pclk);
        chk(32'(interrupt_out_n), 32'h1);
        clk_en <= 1'b1;
        wait_low(100);
        repeat (40) @(posedge pclk);
        chk(32'(interrupt_out_n), 32'h0);
        reg_rd(12'h064, rv);
        chk(rv, 32'h00);
        reg_rd(12'h078, rv);
        chk(rv, 32'h01);
        reg_wr(12'h078, 32'h01);
        repeat (3) @(posedge pclk);
        chk(32'(interrupt_out_n), 32'h1);
        // Pulse, repeat from reload 2: one event every 16 cycles
        reg_wr(12'h060, 32'h00);
        reg_wr(12'h068, 32'h02);
        reg_wr(12'h064, 32'h02);
        reg_wr(12'h060, 32'ha0);
        repeat (60) @(posedge pclk);
        chk(32'(fall_gap), 32'd16);
        chk(32'(lo_len >= 6 && lo_len <= 10), 32'h1);
        reg_wr(12'h064, 32'h55);
        reg_rd(12'h064, rv);
        chk(32'(rv <= 32'h02), 32'h1);
        countdown_irq_enable <= 1'b0;
        reg_wr(12'h078, 32'h01);
        repeat (40) @(posedge pclk);
        chk(32'(interrupt_out_n), 32'h1);
        countdown_irq_enable <= 1'b1;
        reg_wr(12'h060, 32'h00);
        reg_wr(12'h078, 32'h01);
        // Watchdog limit 3 at 16 Hz: restart by rewrite, then timeout
        reg_wr(12'h06c, 32'h0c);
        repeat (3500) @(posedge pclk);
        reg_wr(12'h06c, 32'h0c);
        repeat (3900) @(posedge pclk);
        chk(32'(watchdog_interrupt), 32'h0);
        repeat (3000) @(posedge pclk);
        chk(32'(watchdog_interrupt), 32'h1);
        reg_wr(12'h078, 32'h02);
        reg_wr(12'h06c, 32'h84);
        k = 0;
        while (reset_out_n !== 1'b0 && k < 5000) begin
            @(posedge pclk);
            k++;
        end
        k = 0;
        while (reset_out_n === 1'b0 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        chk(32'(k), 32'd16);
        chk(32'(watchdog_interrupt), 32'h0);
        complete_run();
    end
endmodule
